// ===== logic/iafpc_pkg.sv
// Package: register map, field layout, modes and timing of the flash controller
package iafpc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_RST_PAT = 4'h1;
  localparam logic [3:0] OFS_ADDR_LO = 4'h2;
  localparam logic [3:0] OFS_ADDR_HI = 4'h3;
  localparam logic [3:0] OFS_DATA0 = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hD;
  localparam int unsigned BIT_ERASE_WRITE_ENABLED_STATUS = 7;
  localparam int unsigned BIT_MODE_LO = 4;
  localparam int unsigned BIT_TRIG = 3;
  localparam int unsigned BIT_WSTART = 2;
  localparam int unsigned BIT_RDEN = 1;
  localparam int unsigned BIT_RSTART = 0;
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] CHIP_RESET_VALUE = 8'h55;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] ADDR_HI_MASK = 4'hF;
  localparam int unsigned WORDS_PER_WRITE = 4;
  localparam int unsigned WORDS_PER_BLOCK = 256;
  localparam logic [15:0] UNLOCK_PAT1 = 16'h1A2B;
  localparam logic [15:0] UNLOCK_PAT2 = 16'h3C4D;
  localparam logic [15:0] UNLOCK_PAT3 = 16'h5E6F;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned UNLOCK_WIN_US = 20;
  localparam int unsigned UNLOCK_WIN_CYC = UNLOCK_WIN_US * CLK_MHZ;
  localparam int unsigned OP_US = 2;
  localparam int unsigned OP_CYC = OP_US * CLK_MHZ;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RD_DONE = 0;
  localparam int unsigned IRQ_WR_DONE = 1;
  localparam int unsigned IRQ_ER_DONE = 2;
  localparam int unsigned IRQ_UNLOCK = 3;
  typedef enum logic [1:0] {
    IAFPC_IDLE = 2'b00,
    IAFPC_BUSY = 2'b01,
    IAFPC_STEP = 2'b11
  } iafpc_state_e;
endpackage

// ===== logic/iafpc_timer.sv
// Down counter that runs a timed window and pulses when it expires
`timescale 1ns/100ps
`default_nettype none
module iafpc_timer #(
  parameter int unsigned COUNT = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  output logic running,
  output logic expired
);
  logic [15:0] cnt_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 16'h0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= running && (cnt_reg == 16'h0001) && !abort;
      if (abort) begin
        running <= 1'b0;
        cnt_reg <= 16'h0000;
      end else if (start) begin
        running <= 1'b1;
        cnt_reg <= COUNT[15:0];
      end else if (running) begin
        cnt_reg <= cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0001) begin
          running <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/iafpc_ctrl.sv
// In-application flash controller: registers, unlock, read, write, erase
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Erase works per block, write per four words, read per single word.
// - One erase clears all 256 words of the selected block at once.
// - A good unlock sequence makes hardware set the erase/write-enabled bit.
// - Data registers take writes only while erase/write-enabled or the unlock trigger is high.
// - The write-start bit stays high while programming and self-clears.
// - Reads happen only while read-enable is set.
// - The read-start bit self-clears once the read data is available.
// - Erase picks one of sixteen blocks from the high address low nibble.
// - Write picks one of 1024 units from high nibble and low bits 7..2.
// - Two address, four 16-bit data and two control registers exist.
// - All flash transfers are 16-bit words at the address register pair.
// - Mode codes are 000 write, 001 erase, 011 read, 110 unlock.
// - The unlock trigger starts a timer and clears when it expires.
// - Writing word0 high byte loads the buffer and bumps the address.
// - Writing 55H to the chip reset pattern register resets the chip.
module iafpc_ctrl #(
  parameter int unsigned UNLOCK_CYC = iafpc_pkg::UNLOCK_WIN_CYC,
  parameter int unsigned OP_CYCLES = iafpc_pkg::OP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic chip_reset,
  output logic [11:0] fl_addr,
  output logic [15:0] fl_wdata,
  output logic fl_rd,
  output logic fl_wr,
  output logic fl_erase,
  output logic [1:0] fl_wr_idx,
  input wire logic [15:0] fl_rdata
);
  logic [2:0] mode_reg;
  logic erase_write_enabled_status_reg, trig_reg, wstart_reg, rden_reg, rstart_reg;
  logic [7:0] rst_pat_reg, addr_lo_reg;
  logic [3:0] addr_hi_reg;
  logic [7:0] data_reg [0:7];
  logic [15:0] wbuf_reg [0:3];
  logic [1:0] wbuf_idx_reg;
  localparam int unsigned IAFPC_IRQW = iafpc_pkg::IRQ_W;
  logic [IAFPC_IRQW-1:0] stat_reg, mask_reg;
  iafpc_pkg::iafpc_state_e state_reg;
  logic [15:0] op_cnt_reg;
  logic [1:0] step_reg;
  logic [2:0] op_kind_reg;
  logic unl_run, unl_exp;

  wire [7:0] ctrl_rd = {erase_write_enabled_status_reg, mode_reg, trig_reg, wstart_reg,
                        rden_reg, rstart_reg};
  wire wr_ctrl = reg_write && reg_addr == iafpc_pkg::OFS_CTRL;
  wire wr_data = reg_write && reg_addr >= iafpc_pkg::OFS_DATA0
                 && reg_addr < iafpc_pkg::OFS_IRQ_STAT;
  wire [2:0] data_idx = 3'(reg_addr - iafpc_pkg::OFS_DATA0);
  wire busy = state_reg != iafpc_pkg::IAFPC_IDLE;
  wire [2:0] new_mode = reg_wdata[iafpc_pkg::BIT_MODE_LO +: 3];
  // starts only land when idle; a busy write keeps old start bits
  wire go_rd = wr_ctrl && !busy && reg_wdata[iafpc_pkg::BIT_RSTART]
               && reg_wdata[iafpc_pkg::BIT_RDEN]
               && new_mode == iafpc_pkg::MODE_READ;
  wire go_wr = wr_ctrl && !busy && reg_wdata[iafpc_pkg::BIT_WSTART]
               && erase_write_enabled_status_reg && (new_mode == iafpc_pkg::MODE_WRITE
               || new_mode == iafpc_pkg::MODE_ERASE);
  wire go_unl = wr_ctrl && !busy && reg_wdata[iafpc_pkg::BIT_TRIG]
                && new_mode == iafpc_pkg::MODE_UNLOCK && !trig_reg;
  wire [15:0] word1 = {data_reg[3], data_reg[2]};
  wire [15:0] word2 = {data_reg[5], data_reg[4]};
  wire [15:0] word3 = {data_reg[7], data_reg[6]};
  wire pat_ok = word1 == iafpc_pkg::UNLOCK_PAT1
                && word2 == iafpc_pkg::UNLOCK_PAT2
                && word3 == iafpc_pkg::UNLOCK_PAT3;
  // Unlock window: the patterns may arrive while the timer runs
  wire unl_ok = trig_reg && pat_ok;
  // data writes need erase/write enabled, except during unlock
  wire data_ok = erase_write_enabled_status_reg || trig_reg;
  wire wr_w0_hi = wr_data && data_ok && data_idx == 3'h1;
  wire [11:0] addr_full = {addr_hi_reg, addr_lo_reg};
  wire [11:0] addr_inc = addr_full + 12'h001;
  // erase base address, low byte ignored
  wire [11:0] erase_base = {addr_hi_reg, 8'h00};
  // write unit base, low two bits ignored
  wire [11:0] unit_base = {addr_hi_reg, addr_lo_reg[7:2], 2'b00};
  wire [IAFPC_IRQW-1:0] ev;
  wire op_end = state_reg == iafpc_pkg::IAFPC_BUSY
                && op_cnt_reg == 16'h0001;
  // A write holds the step state until its last word has gone out
  wire leave_step = op_kind_reg != iafpc_pkg::MODE_WRITE
                    || fl_wr_idx == 2'h3;

  iafpc_timer #(.COUNT(UNLOCK_CYC)) u_unlock_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(go_unl),
    .abort(unl_ok),
    .running(unl_run),
    .expired(unl_exp)
  );

  // Control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= 3'h0;
      erase_write_enabled_status_reg <= 1'b0;
      trig_reg <= 1'b0;
      rden_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_reg <= new_mode;
        rden_reg <= reg_wdata[iafpc_pkg::BIT_RDEN];
      end
      // Software may only clear the enabled bit; unlock success wins
      if (unl_ok) begin
        erase_write_enabled_status_reg <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[iafpc_pkg::BIT_ERASE_WRITE_ENABLED_STATUS]) begin
        erase_write_enabled_status_reg <= 1'b0;
      end
      // trigger drops on timeout or on success
      if (go_unl) begin
        trig_reg <= 1'b1;
      end else if (unl_exp || unl_ok) begin
        trig_reg <= 1'b0;
      end
    end
  end

  // Start bits and the operation sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= iafpc_pkg::IAFPC_IDLE;
      wstart_reg <= 1'b0;
      rstart_reg <= 1'b0;
      op_cnt_reg <= 16'h0000;
      step_reg <= 2'h0;
      op_kind_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        iafpc_pkg::IAFPC_IDLE: begin
          if (go_rd || go_wr) begin
            state_reg <= iafpc_pkg::IAFPC_BUSY;
            op_cnt_reg <= OP_CYCLES[15:0];
            op_kind_reg <= new_mode;
            step_reg <= 2'h0;
            wstart_reg <= go_wr;
            rstart_reg <= go_rd;
          end
        end
        iafpc_pkg::IAFPC_BUSY: begin
          op_cnt_reg <= op_cnt_reg - 16'h0001;
          if (op_end) begin
            state_reg <= iafpc_pkg::IAFPC_STEP;
          end
        end
        iafpc_pkg::IAFPC_STEP: begin
          if (leave_step) begin
            state_reg <= iafpc_pkg::IAFPC_IDLE;
            wstart_reg <= 1'b0;
            rstart_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Flash strobes: one word per read, four per write, whole block erase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fl_rd <= 1'b0;
      fl_wr <= 1'b0;
      fl_erase <= 1'b0;
      fl_addr <= 12'h000;
      fl_wdata <= 16'h0000;
      fl_wr_idx <= 2'h0;
    end else begin
      fl_rd <= 1'b0;
      fl_wr <= 1'b0;
      fl_erase <= 1'b0;
      if (op_end) begin
        unique case (op_kind_reg)
          iafpc_pkg::MODE_READ: begin
            fl_rd <= 1'b1;
            fl_addr <= addr_full;
          end
          iafpc_pkg::MODE_ERASE: begin
            fl_erase <= 1'b1;
            fl_addr <= erase_base;
          end
          default: begin
            fl_wr <= 1'b1;
            fl_addr <= unit_base;
            fl_wdata <= wbuf_reg[0];
            fl_wr_idx <= 2'h0;
          end
        endcase
      end else if (state_reg == iafpc_pkg::IAFPC_STEP
                   && op_kind_reg == iafpc_pkg::MODE_WRITE
                   && fl_wr_idx != 2'h3) begin
        // Remaining three words of the unit, back to back
        fl_wr <= 1'b1;
        fl_wr_idx <= fl_wr_idx + 2'h1;
        fl_wdata <= wbuf_reg[fl_wr_idx + 2'h1];
        fl_addr <= unit_base + {10'h000, fl_wr_idx + 2'h1};
      end
    end
  end

  // Address and data registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_lo_reg <= iafpc_pkg::RESET_BYTE;
      addr_hi_reg <= 4'h0;
      rst_pat_reg <= iafpc_pkg::RESET_BYTE;
      wbuf_idx_reg <= 2'h0;
      for (int i = 0; i < 8; i++) begin
        data_reg[i] <= iafpc_pkg::RESET_BYTE;
      end
      for (int i = 0; i < 4; i++) begin
        wbuf_reg[i] <= 16'h0000;
      end
    end else begin
      if (reg_write && reg_addr == iafpc_pkg::OFS_RST_PAT) begin
        rst_pat_reg <= reg_wdata;
      end
      if (wr_w0_hi) begin
        wbuf_reg[wbuf_idx_reg] <= {reg_wdata, data_reg[0]};
        wbuf_idx_reg <= wbuf_idx_reg + 2'h1;
        addr_lo_reg <= addr_inc[7:0];
        addr_hi_reg <= addr_inc[11:8];
      end else begin
        if (reg_write && reg_addr == iafpc_pkg::OFS_ADDR_LO) begin
          addr_lo_reg <= reg_wdata;
          wbuf_idx_reg <= reg_wdata[1:0];
        end
        if (reg_write && reg_addr == iafpc_pkg::OFS_ADDR_HI) begin
          addr_hi_reg <= reg_wdata[3:0] & iafpc_pkg::ADDR_HI_MASK;
        end
      end
      if (wr_data && data_ok) begin
        data_reg[data_idx] <= reg_wdata;
      end
      if (fl_rd) begin
        data_reg[0] <= fl_rdata[7:0];
        data_reg[1] <= fl_rdata[15:8];
      end
    end
  end

  // Events, sticky status and mask; a set beats a same-cycle clear
  assign ev[iafpc_pkg::IRQ_RD_DONE] = fl_rd;
  assign ev[iafpc_pkg::IRQ_WR_DONE] = fl_wr && fl_wr_idx == 2'h3;
  assign ev[iafpc_pkg::IRQ_ER_DONE] = fl_erase;
  assign ev[iafpc_pkg::IRQ_UNLOCK] = unl_ok;
  wire wr_stat = reg_write && reg_addr == iafpc_pkg::OFS_IRQ_STAT;
  wire [IAFPC_IRQW-1:0] clr = wr_stat ? reg_wdata[IAFPC_IRQW-1:0] : '0;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~clr) | ev;
      if (reg_write && reg_addr == iafpc_pkg::OFS_IRQ_MASK) begin
        mask_reg <= reg_wdata[IAFPC_IRQW-1:0];
      end
      irq <= |(((stat_reg & ~clr) | ev) & mask_reg);
      chip_reset <= reg_write && reg_addr == iafpc_pkg::OFS_RST_PAT
                    && reg_wdata == iafpc_pkg::CHIP_RESET_VALUE;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  wire data_sel = reg_addr >= iafpc_pkg::OFS_DATA0
                  && reg_addr < iafpc_pkg::OFS_IRQ_STAT;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == iafpc_pkg::OFS_CTRL) rd_mux = ctrl_rd;
    else if (reg_addr == iafpc_pkg::OFS_RST_PAT) rd_mux = rst_pat_reg;
    else if (reg_addr == iafpc_pkg::OFS_ADDR_LO) rd_mux = addr_lo_reg;
    else if (reg_addr == iafpc_pkg::OFS_ADDR_HI) rd_mux = {4'h0, addr_hi_reg};
    else if (reg_addr == iafpc_pkg::OFS_IRQ_STAT) rd_mux = {4'h0, stat_reg};
    else if (reg_addr == iafpc_pkg::OFS_IRQ_MASK) rd_mux = {4'h0, mask_reg};
    else if (data_sel) rd_mux = data_reg[data_idx];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
  end

  a_read_needs_en: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(rstart_reg) |-> rden_reg)
    else $error("read started without read enable");
  a_wstart_clears: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(wstart_reg) |-> ##[1:300] $fell(wstart_reg))
    else $error("write start did not clear");
  a_rd_clear_data: assert property (
    @(posedge ref_clk) disable iff (rst)
    fl_rd |=> !rstart_reg)
    else $error("read start not cleared after data");
  a_erase_write_enabled_status_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    unl_ok |=> erase_write_enabled_status_reg)
    else $error("enabled bit not set after unlock");
  a_data_locked: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_data && !erase_write_enabled_status_reg && !trig_reg |=> $stable(data_reg[3]))
    else $error("data register written while locked");
  a_erase_block: assert property (
    @(posedge ref_clk) disable iff (rst)
    fl_erase |-> fl_addr[7:0] == 8'h00)
    else $error("erase address not block aligned");
  a_write_four: assert property (
    @(posedge ref_clk) disable iff (rst)
    fl_wr && fl_wr_idx == 2'h0 |=> fl_wr [*3])
    else $error("write unit not four words");
  a_chip_reset: assert property (
    @(posedge ref_clk) disable iff (rst)
    reg_write && reg_addr == iafpc_pkg::OFS_RST_PAT
    && reg_wdata == iafpc_pkg::CHIP_RESET_VALUE |=> chip_reset)
    else $error("no chip reset on pattern");
  a_addr_bump: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_w0_hi |=> {addr_hi_reg, addr_lo_reg} == $past(addr_inc))
    else $error("address not incremented");
  a_busy_ignore: assert property (
    @(posedge ref_clk) disable iff (rst)
    busy && wr_ctrl |=> $stable(op_kind_reg))
    else $error("start taken while busy");
  a_trig_drop: assert property (
    @(posedge ref_clk) disable iff (rst)
    unl_exp |=> !trig_reg)
    else $error("trigger not cleared at timeout");
  a_read_one_word: assert property (
    @(posedge ref_clk) disable iff (rst)
    fl_rd |=> !fl_rd)
    else $error("more than one word read per operation");
  a_unit_aligned: assert property (
    @(posedge ref_clk) disable iff (rst)
    fl_wr && fl_wr_idx == 2'h0 |-> fl_addr[1:0] == 2'b00)
    else $error("write unit not aligned");
  a_wr_needs_en: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(wstart_reg) |-> erase_write_enabled_status_reg)
    else $error("program started while locked");
endmodule
`default_nettype wire

// ===== bench/iafpc_flash_model.sv
// Behavioural program flash array on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
module iafpc_flash_model (
  input wire logic ref_clk,
  input wire logic [11:0] fl_addr,
  input wire logic [15:0] fl_wdata,
  input wire logic fl_rd,
  input wire logic fl_wr,
  input wire logic fl_erase,
  input wire logic [1:0] fl_wr_idx,
  output logic [15:0] fl_rdata
);
  logic [15:0] mem [0:4095];
  logic [11:0] wr_word;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'(i) ^ 16'hA5C3;
    end
  end
  assign wr_word = {fl_addr[11:2], fl_wr_idx};
  // Outside a read strobe the bus shows the inverse, never a usable word
  assign fl_rdata = fl_rd ? mem[fl_addr] : ~mem[fl_addr];
  always @(posedge ref_clk) begin
    if (fl_erase) begin
      for (int i = 0; i < 256; i++) begin
        mem[{fl_addr[11:8], 8'(i)}] <= 16'hFFFF;
      end
    end
    // Programming only clears bits, so an unerased word comes out corrupt
    if (fl_wr) begin
      mem[wr_word] <= mem[wr_word] & fl_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_iafpc_ctrl.sv
// Self-checking bench for the in-application flash controller
`timescale 1ns/100ps
`default_nettype none
module tb_iafpc_ctrl;
  localparam logic [3:0] CT = iafpc_pkg::OFS_CTRL;
  localparam logic [3:0] AL = iafpc_pkg::OFS_ADDR_LO;
  localparam logic [3:0] AH = iafpc_pkg::OFS_ADDR_HI;
  localparam logic [3:0] D0 = iafpc_pkg::OFS_DATA0;
  localparam logic [3:0] ST = iafpc_pkg::OFS_IRQ_STAT;
  localparam logic [3:0] MK = iafpc_pkg::OFS_IRQ_MASK;
  logic ref_clk, rst, reg_write, reg_read, irq, chip_reset;
  logic fl_rd, fl_wr, fl_erase;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [11:0] fl_addr, er_addr;
  logic [15:0] fl_wdata, fl_rdata;
  logic [1:0] fl_wr_idx;
  int mismatches = 0;
  int total_checks = 0;
  int n_rd = 0;
  int n_wr = 0;
  int n_er = 0;
  int n_cr = 0;

  iafpc_ctrl #(.UNLOCK_CYC(50), .OP_CYCLES(5)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .chip_reset(chip_reset),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rd(fl_rd),
    .fl_wr(fl_wr), .fl_erase(fl_erase), .fl_wr_idx(fl_wr_idx),
    .fl_rdata(fl_rdata));
  iafpc_flash_model flash (
    .ref_clk(ref_clk), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rd(fl_rd), .fl_wr(fl_wr), .fl_erase(fl_erase),
    .fl_wr_idx(fl_wr_idx), .fl_rdata(fl_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    n_rd += int'(fl_rd === 1'b1);
    n_wr += int'(fl_wr === 1'b1);
    n_er += int'(fl_erase === 1'b1);
    n_cr += int'(chip_reset === 1'b1);
    if (fl_erase === 1'b1) begin
      er_addr = fl_addr;
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_clr(input logic [7:0] m);
    logic [7:0] d;
    int n;
    n = 0;
    do begin
      rd(CT, d);
      n++;
    end while ((d & m) != 8'h00 && n < 100);
    chk("start bit", 16'h0000, {8'h00, d & m});
  endtask

  task automatic read_start(input logic [11:0] a, input logic [15:0] e);
    logic [7:0] lo, hi;
    wr(AH, {4'h0, a[11:8]});
    wr(AL, a[7:0]);
    wr(CT, 8'hB3);
    wait_clr(8'h01);
    rd(D0, lo);
    rd(D0 + 4'h1, hi);
    chk("flash word", e, {hi, lo});
  endtask

  task automatic s_reset;
    logic [7:0] d;
    rd(CT, d);
    chk("control at reset", 16'h0000, {8'h00, d});
    wr(CT, 8'h80);
    wr(D0, 8'hAA);
    rd(CT, d);
    chk("enabled bit by software", 16'h0000, {8'h00, d});
    rd(D0, d);
    chk("locked data write", 16'h0000, {8'h00, d});
    rd(4'hE, d);
    chk("unmapped read", 16'h0000, {8'h00, d});
  endtask

  task automatic s_read;
    logic [7:0] d, h;
    wr(AH, 8'h13);
    rd(AH, d);
    chk("address high", 16'h0003, {8'h00, d});
    wr(AL, 8'h47);
    wr(CT, 8'hB1);
    repeat (20) @(posedge ref_clk);
    chk("read without enable", 16'h0000, 16'(n_rd));
    wr(CT, 8'hB3);
    // A second start while the first read runs must be dropped
    wr(CT, 8'hB3);
    wait_clr(8'h01);
    chk("read strobes", 16'h0001, 16'(n_rd));
    rd(D0, d);
    rd(D0 + 4'h1, h);
    chk("read word", 16'h0347 ^ 16'hA5C3, {h, d});
  endtask

  task automatic s_unlock;
    logic [15:0] p [3];
    logic [7:0] d;
    int n;
    p = '{iafpc_pkg::UNLOCK_PAT1, iafpc_pkg::UNLOCK_PAT2,
          iafpc_pkg::UNLOCK_PAT3};
    wr(CT, 8'hE8);
    repeat (60) @(posedge ref_clk);
    rd(CT, d);
    chk("unlock timeout", 16'h0000, {8'h00, d & 8'h88});
    wr(CT, 8'hE8);
    for (int i = 0; i < 3; i++) begin
      wr(D0 + 4'(2 * i + 2), p[i][7:0]);
      wr(D0 + 4'(2 * i + 3), p[i][15:8]);
    end
    n = 0;
    do begin
      rd(CT, d);
      n++;
    end while (d[7] !== 1'b1 && n < 20);
    chk("unlock done", 16'h0080, {8'h00, d & 8'h88});
    // Data pair one now holds a pattern, so an alias would show here
    rd(4'hE, d);
    chk("unmapped read", 16'h0000, {8'h00, d});
  endtask

  task automatic s_erase;
    wr(AH, 8'h13);
    wr(AL, 8'hC7);
    wr(CT, 8'h94);
    wait_clr(8'h04);
    chk("erase strobes", 16'h0001, 16'(n_er));
    chk("erase address", 16'h0300, {4'h0, er_addr});
    read_start(12'h300, 16'hFFFF);
    read_start(12'h3FF, 16'hFFFF);
    read_start(12'h2FF, 16'h02FF ^ 16'hA5C3);
  endtask

  task automatic s_write;
    logic [15:0] w [4];
    logic [7:0] d;
    w = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
    // The last flash read left another block in the high address
    wr(AH, 8'h03);
    wr(AL, 8'h44);
    for (int i = 0; i < 4; i++) begin
      wr(D0, w[i][7:0]);
      wr(D0 + 4'h1, w[i][15:8]);
      if (i == 0) begin
        rd(AL, d);
        chk("address after load", 16'h0045, {8'h00, d});
      end
    end
    // Low two address bits must not move the unit
    wr(AL, 8'h46);
    wr(CT, 8'h84);
    wait_clr(8'h04);
    chk("program strobes", 16'h0004, 16'(n_wr));
    for (int i = 0; i < 4; i++) begin
      read_start(12'h344 + 12'(i), w[i]);
    end
    read_start(12'h348, 16'hFFFF);
  endtask

  task automatic s_irq;
    logic [7:0] d;
    rd(ST, d);
    chk("event status", 16'h000F, {8'h00, d});
    chk("masked interrupt", 16'h0000, {15'h0000, irq});
    wr(MK, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk("interrupt", 16'h0001, {15'h0000, irq});
    wr(ST, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk("cleared interrupt", 16'h0000, {15'h0000, irq});
    rd(ST, d);
    chk("status after clear", 16'h000D, {8'h00, d});
  endtask

  task automatic s_chip_reset;
    wr(iafpc_pkg::OFS_RST_PAT, 8'h54);
    repeat (3) @(posedge ref_clk);
    chk("no chip reset", 16'h0000, 16'(n_cr));
    wr(iafpc_pkg::OFS_RST_PAT, 8'h55);
    repeat (3) @(posedge ref_clk);
    chk("chip reset", 16'h0001, 16'(n_cr));
  endtask

  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    s_reset();
    s_read();
    s_unlock();
    s_erase();
    s_write();
    s_irq();
    s_chip_reset();
    end_of_test();
  end

  // Scenarios take well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
